// >>> dtl_timer.sv
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
module dtl_timer
    import dtl_pkg::*;
#(
    parameter int PRE_DIV = PRESCALE
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output      logic              hreadyout,
    output      logic              hresp,
    output      logic [31:0]       hrdata,
    input  wire logic              capture_input_pin,
    input  wire logic              halt_mode,
    input  wire logic              global_irq_mask,
    output      logic              irq_timebase1,
    output      logic              irq_timebase2,
    output      logic              irq_capture,
    output      logic              irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic               dp_wr;
        logic               dp_rd;
        logic [ADDR_W-1:0]  dp_addr;
        logic [31:0]        rdata;
        logic [7:0]         cnt1;
        logic               half;
        logic [7:0]         cnt2;
        logic [7:0]         reload_value_reg;
        logic [7:0]         capture_value_reg;
        logic               capture_irq_enable;
        logic               capture_flag;
        logic               period_double_select;
        logic               timebase1_irq_enable;
        logic               timebase1_flag;
        logic               timebase2_irq_enable;
        logic               timebase2_flag;
        logic [NUM_EV-1:0]  irq_status;
        logic [NUM_EV-1:0]  irq_mask;
    } dtl_state_s;

    dtl_state_s st;
    dtl_state_s next_st;
    logic       tick;
    logic       cap_edge;
    logic       ovf1;
    logic       ovf2;
    logic       cap_take;
    logic       rd_first;
    logic       rd_second;
    logic       rd_capture;
    logic [NUM_EV-1:0] ev;

    dtl_prescaler #(.DIV(PRE_DIV)) u_pre (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .halt_mode (halt_mode),
        .tick      (tick)
    );

    dtl_edge_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin      (capture_input_pin),
        .any_edge (cap_edge)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == (ADDR_W)'({idx, 2'b00}));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Overflow one: 250 ticks, or every second wrap when doubled
    assign ovf1 = tick && (st.cnt1 == TB1_LAST)
                  && (!st.period_double_select || st.half);
    assign ovf2 = tick && (st.cnt2 == CNT_MAX);
    // Halt stops the counter but edges are still seen for wakeup
    assign cap_take = cap_edge && !st.capture_flag;

    assign rd_first   = st.dp_rd && hit(st.dp_addr, IDX_FIRST_CSR);
    assign rd_second  = st.dp_rd && hit(st.dp_addr, IDX_SECOND_CSR);
    assign rd_capture = st.dp_rd && hit(st.dp_addr, IDX_CAPTURE);
    assign ev = {cap_take, ovf2, ovf1};

    always_comb begin
        next_st = st;
        // Bus address phase, zero wait states
        next_st.dp_wr = hsel && hready && htrans[1] && hwrite;
        next_st.dp_rd = hsel && hready && htrans[1] && !hwrite;
        next_st.dp_addr = haddr;

        // Counter one
        if (tick) begin
            if (st.cnt1 == TB1_LAST) begin
                next_st.cnt1 = 8'h00;
                next_st.half = !st.half;
            end else begin
                next_st.cnt1 = st.cnt1 + 8'h01;
            end
        end

        // Counter two; reload sampled only at overflow
        if (tick) begin
            if (ovf2) begin
                next_st.cnt2 = st.reload_value_reg;
            end else begin
                next_st.cnt2 = st.cnt2 + 8'h01;
            end
        end

        if (cap_take) begin
            next_st.capture_value_reg = st.cnt1;
        end

        // Read side effects first so a same-cycle set wins
        if (rd_first) begin
            next_st.timebase1_flag = 1'b0;
        end
        if (rd_second) begin
            next_st.timebase2_flag = 1'b0;
        end
        if (rd_capture) begin
            next_st.capture_flag = 1'b0;
        end
        if (ovf1) begin
            next_st.timebase1_flag = 1'b1;
        end
        if (ovf2) begin
            next_st.timebase2_flag = 1'b1;
        end
        if (cap_take) begin
            next_st.capture_flag = 1'b1;
        end

        // Writes; flag bits are not writable
        if (st.dp_wr) begin
            if (hit(st.dp_addr, IDX_FIRST_CSR)) begin
                next_st.capture_irq_enable   = hwdata[POS_CAP_IE];
                next_st.period_double_select = hwdata[POS_PERIOD2];
                next_st.timebase1_irq_enable = hwdata[POS_TB1_IE];
            end
            if (hit(st.dp_addr, IDX_SECOND_CSR)) begin
                next_st.timebase2_irq_enable = hwdata[POS_TB2_IE];
            end
            if (hit(st.dp_addr, IDX_RELOAD)) begin
                next_st.reload_value_reg = hwdata[7:0];
            end
            if (hit(st.dp_addr, IDX_IRQ_STATUS)) begin
                next_st.irq_status = st.irq_status & ~hwdata[NUM_EV-1:0];
            end
            if (hit(st.dp_addr, IDX_IRQ_MASK)) begin
                next_st.irq_mask = hwdata[NUM_EV-1:0];
            end
        end
        // Sticky event status, set beats write-one-clear
        next_st.irq_status = next_st.irq_status | ev;

        // Read data registered for the data phase
        // Flags as updated at this edge, so an event here is read, not lost
        next_st.rdata = 32'h0000_0000;
        if (next_st.dp_rd) begin
            if (hit(haddr, IDX_FIRST_CSR)) begin
                next_st.rdata[POS_CAP_IE]   = st.capture_irq_enable;
                next_st.rdata[POS_CAP_FLAG] = next_st.capture_flag;
                next_st.rdata[POS_PERIOD2]  = st.period_double_select;
                next_st.rdata[POS_TB1_IE]   = st.timebase1_irq_enable;
                next_st.rdata[POS_TB1_FLAG] = next_st.timebase1_flag;
            end
            if (hit(haddr, IDX_SECOND_CSR)) begin
                next_st.rdata[POS_TB2_IE]   = st.timebase2_irq_enable;
                next_st.rdata[POS_TB2_FLAG] = next_st.timebase2_flag;
            end
            if (hit(haddr, IDX_RELOAD)) begin
                next_st.rdata[7:0] = st.reload_value_reg;
            end
            if (hit(haddr, IDX_SECOND_CNT)) begin
                next_st.rdata[7:0] = st.cnt2;
            end
            if (hit(haddr, IDX_CAPTURE)) begin
                next_st.rdata[7:0] = next_st.capture_value_reg;
            end
            if (hit(haddr, IDX_IRQ_STATUS)) begin
                next_st.rdata[NUM_EV-1:0] = st.irq_status;
            end
            if (hit(haddr, IDX_IRQ_MASK)) begin
                next_st.rdata[NUM_EV-1:0] = st.irq_mask;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;
    // Per-vector requests also need the global mask cleared
    assign irq_timebase1 = st.timebase1_flag && st.timebase1_irq_enable
                           && !global_irq_mask;
    assign irq_timebase2 = st.timebase2_flag && st.timebase2_irq_enable
                           && !global_irq_mask;
    assign irq_capture   = st.capture_flag && st.capture_irq_enable
                           && !global_irq_mask;
    assign irq = |(st.irq_status & st.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    sequence s_tb1_wrap;
        tick && st.cnt1 == TB1_LAST;
    endsequence

    property p_wrap1;
        @(posedge hclk) disable iff (!hresetn)
        s_tb1_wrap |=> st.cnt1 == 8'h00;
    endproperty
    a_wrap1: assert property (p_wrap1) else $error("counter one did not wrap");

    property p_count1;
        @(posedge hclk) disable iff (!hresetn)
        tick && st.cnt1 != TB1_LAST |=> st.cnt1 == $past(st.cnt1) + 8'h01;
    endproperty
    a_count1: assert property (p_count1) else $error("counter one missed step");

    property p_single;
        @(posedge hclk) disable iff (!hresetn)
        (s_tb1_wrap and (!st.half && st.period_double_select))
            |=> !$rose(st.timebase1_flag);
    endproperty
    a_single: assert property (p_single) else $error("doubled period too short");

    property p_flag1;
        @(posedge hclk) disable iff (!hresetn)
        ovf1 |=> st.timebase1_flag;
    endproperty
    a_flag1: assert property (p_flag1) else $error("flag one not set");

    property p_clr1;
        @(posedge hclk) disable iff (!hresetn)
        rd_first && !ovf1 |=> !st.timebase1_flag;
    endproperty
    a_clr1: assert property (p_clr1) else $error("flag one not cleared");

    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        ovf2 |=> st.cnt2 == $past(st.reload_value_reg) && st.timebase2_flag;
    endproperty
    a_reload: assert property (p_reload) else $error("counter two reload wrong");

    property p_clr2;
        @(posedge hclk) disable iff (!hresetn)
        rd_second && !ovf2 |=> !st.timebase2_flag;
    endproperty
    a_clr2: assert property (p_clr2) else $error("flag two not cleared");

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        cap_take |=> st.capture_flag && st.capture_value_reg == $past(st.cnt1);
    endproperty
    a_capture: assert property (p_capture) else $error("capture not latched");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        st.capture_flag && !rd_capture |=> $stable(st.capture_value_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("capture overwritten");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        halt_mode [*2] |=> $stable(st.cnt1) && $stable(st.cnt2);
    endproperty
    a_halt: assert property (p_halt) else $error("counted in halt");

    property p_gmask;
        @(posedge hclk) disable iff (!hresetn)
        global_irq_mask |-> !irq_timebase1 && !irq_timebase2 && !irq_capture;
    endproperty
    a_gmask: assert property (p_gmask) else $error("irq despite global mask");

    sequence s_reload_write;
        st.dp_wr && hit(st.dp_addr, IDX_RELOAD);
    endsequence

    property p_count2;
        @(posedge hclk) disable iff (!hresetn)
        tick && !ovf2 |=> st.cnt2 == $past(st.cnt2) + 8'h01;
    endproperty
    a_count2: assert property (p_count2) else $error("counter two missed step");

    property p_reload_write;
        @(posedge hclk) disable iff (!hresetn)
        (s_reload_write and (!ovf2)) |=> st.cnt2 == $past(st.cnt2) + {7'h00, $past(tick)};
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("count disturbed");

    property p_clr_cap;
        @(posedge hclk) disable iff (!hresetn)
        rd_capture && !cap_take |=> !st.capture_flag;
    endproperty
    a_clr_cap: assert property (p_clr_cap) else $error("capture flag not cleared");

    property p_ignore;
        @(posedge hclk) disable iff (!hresetn)
        cap_edge && st.capture_flag |=> $stable(st.capture_value_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("capture while flag set");

    property p_win1;
        @(posedge hclk) disable iff (!hresetn)
        ovf1 && rd_first |=> st.timebase1_flag;
    endproperty
    a_win1: assert property (p_win1) else $error("read clear beat overflow");

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (|ev) |=> (st.irq_status & $past(ev)) == $past(ev);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event status not set");

    property p_halt_tick;
        @(posedge hclk) disable iff (!hresetn)
        halt_mode [*2] |-> !tick;
    endproperty
    a_halt_tick: assert property (p_halt_tick) else $error("tick during halt");
endmodule

// >>> dtl_pkg.sv
package dtl_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SECOND_CSR  = 8'h08;
    localparam logic [7:0] IDX_RELOAD      = 8'h09;
    localparam logic [7:0] IDX_SECOND_CNT  = 8'h0A;
    localparam logic [7:0] IDX_FIRST_CSR   = 8'h0B;
    localparam logic [7:0] IDX_CAPTURE     = 8'h0C;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h0D;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h0E;
    localparam int         ADDR_W          = 12;

    // First control/status fields
    localparam int POS_CAP_IE   = 7;
    localparam int POS_CAP_FLAG = 6;
    localparam int POS_PERIOD2  = 5;
    localparam int POS_TB1_IE   = 4;
    localparam int POS_TB1_FLAG = 3;
    // Second control/status fields
    localparam int POS_TB2_IE   = 1;
    localparam int POS_TB2_FLAG = 0;
    // Interrupt status / mask layout
    localparam int POS_EV_TB1   = 0;
    localparam int POS_EV_TB2   = 1;
    localparam int POS_EV_CAP   = 2;
    localparam int NUM_EV       = 3;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Timing
    localparam int          PRESCALE      = 32;
    localparam logic [7:0]  TB1_LAST      = 8'hF9;
    localparam logic [7:0]  CNT_MAX       = 8'hFF;
    localparam int          CLK_HZ        = 10000000;
    localparam int          OSC_REF_HZ    = 8000000;
    localparam int          STEP_NS       = 4000;
    localparam int          PERIOD_MAX_NS = 1024000;
    localparam int          PERIOD_STEPS  = PERIOD_MAX_NS / STEP_NS;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

endpackage

// >>> dtl_prescaler.sv
`timescale 1ns/1ns
module dtl_prescaler
    import dtl_pkg::*;
#(
    parameter int DIV = PRESCALE
)(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic halt_mode,
    output      logic tick
);
    typedef struct packed {
        logic [$clog2(DIV)-1:0] cnt;
        logic                   tick;
    } dtl_pre_s;

    dtl_pre_s st;
    dtl_pre_s next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        // Halt freezes the divider so both counters stop together
        if (!halt_mode) begin
            if (st.cnt == ($clog2(DIV))'(DIV - 1)) begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    property p_tick_spacing;
        @(posedge hclk) disable iff (!hresetn)
        tick |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too long");
endmodule

// >>> dtl_edge_sync.sv
`timescale 1ns/1ns
module dtl_edge_sync
    import dtl_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output      logic any_edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dtl_sync_s;

    dtl_sync_s st;
    dtl_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Only the synchronised stages feed the detector
    assign any_edge = st.s2 ^ st.s3;
endmodule

// >>> dual_timebase_lite_timer_test.sv
`timescale 1ns/1ns
module dual_timebase_lite_timer_test;
    import dtl_pkg::*;

    // Short prescale keeps every period within 1000 cycles
    localparam int PRE = 2;

    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic              capture_input_pin;
    logic              halt_mode;
    logic              global_irq_mask;
    logic              irq_timebase1;
    logic              irq_timebase2;
    logic              irq_capture;
    logic              irq;
    int                errors;
    int                num_checks;
    int                cyc;
    logic [31:0]       a;
    logic [31:0]       b;
    logic [31:0]       c;
    int                v1;

    dtl_timer #(.PRE_DIV(PRE)) dtl_timer_inst (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .hrdata            (hrdata),
        .capture_input_pin (capture_input_pin),
        .halt_mode         (halt_mode),
        .global_irq_mask   (global_irq_mask),
        .irq_timebase1     (irq_timebase1),
        .irq_timebase2     (irq_timebase2),
        .irq_capture       (irq_capture),
        .irq               (irq)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Ready and read data are both taken at the rising edge that ends the phase
    task automatic wait_ready(output logic [31:0] d);
        int n;
        n = 0;
        d = '0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            finish_test();
        end else begin
            d = hrdata;
        end
    endtask

    // Entered right after a rising edge; leaves right after the data phase edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr  <= {2'b00, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
        check("hresp okay", 32'(hresp), 32'h0);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        bus(idx, 1'b0, 32'h0, d);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        bus(idx, 1'b1, d, unused);
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (irq !== 1'b1 && n < 3000);
        t = 0;
        if (irq !== 1'b1) begin
            errors++;
            finish_test();
        end else begin
            t = cyc;
            @(posedge hclk);
        end
    endtask

    // First rise may be partial, so the interval between the next two is measured
    task automatic measure(input string what, input int exp);
        int t0;
        int t1;
        wr(IDX_IRQ_STATUS, 32'h7);
        wait_irq(t0);
        wr(IDX_IRQ_STATUS, 32'h7);
        wait_irq(t1);
        check(what, 32'(t1 - t0), 32'(exp));
    endtask

    task automatic pin_edge();
        capture_input_pin <= ~capture_input_pin;
        repeat (6) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        num_checks = 0;
        cyc = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        capture_input_pin = 1'b0;
        halt_mode = 1'b0;
        global_irq_mask = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(IDX_SECOND_CSR, a);
        check("second csr reset", a, 32'h0);
        rd(IDX_RELOAD, a);
        check("reload reset", a, 32'h0);
        rd(IDX_FIRST_CSR, a);
        check("first csr reset", a, 32'h0);
        rd(IDX_CAPTURE, a);
        check("capture reset", a, 32'h0);
        rd(IDX_IRQ_MASK, a);
        check("mask reset", a, 32'h0);
        wr(8'h0F, 32'hFF);
        rd(8'h0F, a);
        check("unmapped", a, 32'h0);
        // Counter two rate and undisturbed count on reload write
        rd(IDX_SECOND_CNT, a);
        repeat (20) @(posedge hclk);
        rd(IDX_SECOND_CNT, b);
        check("cnt2 rate", b - a, 32'hB);
        wr(IDX_RELOAD, 32'hF0);
        rd(IDX_SECOND_CNT, c);
        check("cnt2 undisturbed", c - b, 32'h2);
        rd(IDX_RELOAD, a);
        check("reload rw", a, 32'hF0);
        wr(IDX_SECOND_CSR, 32'h2);
        wr(IDX_IRQ_MASK, 32'h2);
        measure("cnt2 period F0", PRE * 16);
        check("irq tb2", 32'(irq_timebase2), 32'h1);
        global_irq_mask <= 1'b1;
        @(posedge hclk);
        @(negedge hclk);
        check("irq tb2 masked", 32'(irq_timebase2), 32'h0);
        global_irq_mask <= 1'b0;
        @(posedge hclk);
        rd(IDX_SECOND_CSR, a);
        check("second csr flag", a, 32'h3);
        rd(IDX_SECOND_CSR, a);
        check("second csr cleared", a, 32'h2);
        wr(IDX_RELOAD, 32'h0);
        measure("cnt2 period 00", PRE * 256);
        // Counter one periods
        wr(IDX_IRQ_MASK, 32'h1);
        measure("cnt1 period", PRE * 250);
        wr(IDX_FIRST_CSR, 32'h30);
        measure("cnt1 doubled", PRE * 500);
        check("irq tb1", 32'(irq_timebase1), 32'h1);
        rd(IDX_FIRST_CSR, a);
        check("first csr flag", a, 32'h38);
        rd(IDX_FIRST_CSR, a);
        check("first csr cleared", a, 32'h30);
        check("irq tb1 off", 32'(irq_timebase1), 32'h0);
        wr(IDX_IRQ_MASK, 32'h0);
        // The mask lands at the data edge, so look one cycle later
        @(posedge hclk);
        check("irq masked", 32'(irq), 32'h0);
        // Capture, with the counters frozen so values are exact
        wr(IDX_FIRST_CSR, 32'h80);
        halt_mode <= 1'b1;
        pin_edge();
        check("irq cap", 32'(irq_capture), 32'h1);
        rd(IDX_FIRST_CSR, a);
        check("cap flag", a & 32'h40, 32'h40);
        rd(IDX_SECOND_CNT, a);
        repeat (8) @(posedge hclk);
        rd(IDX_SECOND_CNT, b);
        check("halt freeze", b, a);
        // Each 20-cycle run advances counter one by ten ticks
        halt_mode <= 1'b0;
        repeat (20) @(posedge hclk);
        halt_mode <= 1'b1;
        pin_edge();
        rd(IDX_CAPTURE, a);
        v1 = int'(a);
        @(posedge hclk);
        check("irq cap cleared", 32'(irq_capture), 32'h0);
        rd(IDX_CAPTURE, b);
        check("cap held", b, a);
        halt_mode <= 1'b0;
        repeat (20) @(posedge hclk);
        halt_mode <= 1'b1;
        pin_edge();
        // Second edge was ignored, so both runs lie between the captures
        rd(IDX_CAPTURE, c);
        check("cap value", c, 32'((v1 + 20) % 250));
        finish_test();
    end
endmodule
